// ### line_edges.v
// edge detector for synchronised lanes
module line_edges #(
	parameter WIDTH = 1	// number of lanes
) (
	input  wire             clk_sys_in,	// system clock
	input  wire             nrst_in,	// synchronous reset, active low
	input  wire             ce_in,	// clock enable
	input  wire [WIDTH-1:0] level_in,	// synchronised levels
	output wire [WIDTH-1:0] rise_out,	// one-cycle pulse on 0 to 1
	output wire [WIDTH-1:0] fall_out	// one-cycle pulse on 1 to 0
);

	reg [WIDTH-1:0] prev_q;	// level seen on the previous enabled edge

	////////////////////////////////////////////////////////////////
	// remember the last level; reset to the idle-high bus state
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			prev_q <= {WIDTH{1'b1}};
		end else if (ce_in) begin
			prev_q <= level_in;
		end
	end

	// pulses are only meaningful while the clock enable is high
	assign rise_out = level_in & ~prev_q & {WIDTH{ce_in}};
	assign fall_out = ~level_in & prev_q & {WIDTH{ce_in}};

endmodule // line_edges

// ### line_sync.v
// two flip-flop synchroniser for pin inputs
module line_sync #(
	parameter WIDTH = 1	// number of lanes
) (
	input  wire             clk_sys_in,	// system clock
	input  wire             nrst_in,	// synchronous reset, active low
	input  wire             ce_in,	// clock enable
	input  wire [WIDTH-1:0] async_in,	// lanes from outside the domain
	output wire [WIDTH-1:0] sync_out	// lanes safe to read
);

	reg [WIDTH-1:0] meta_q;	// first stage, read only by the second
	reg [WIDTH-1:0] sync_q;	// second stage

	////////////////////////////////////////////////////////////////
	// two stages, frozen while the clock enable is low
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else if (ce_in) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // line_sync

// ### serial_host.sv
// host model acting as i2c or spi master on the serial pins
module serial_host (
	output logic      scl_out,	// serial clock, still outside frames
	output logic      sda_low_out,	// 1 pulls the data line low
	output logic      ss_n_out,	// spi select, address bit two in i2c
	output logic      mosi_out,	// spi data towards the device
	input  wire logic sda_in	// resolved data line
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial begin
		scl_out = 1'b0;
		sda_low_out = 1'b0;
		ss_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// start: data falls while the clock is high
	task automatic i2c_start();
		#1 scl_out = 1'b1;
		#80 sda_low_out = 1'b1;
		#40 scl_out = 1'b0;
	endtask
	// one byte msb first, data moves only while the clock is low, bits read at each rise, acknowledge 20 ns after the ninth
	task automatic i2c_byte(input logic [7:0] b, output logic ack, output logic [7:0] got);
		for (int i = 7; i >= 0; i--) begin
			#30 sda_low_out = ~b[i];
			#10 scl_out = 1'b1;
			got[i] = sda_in;
			#40 scl_out = 1'b0;
		end
		#30 sda_low_out = 1'b0;
		#10 scl_out = 1'b1;
		#20 ack = ~sda_in;
		#20 scl_out = 1'b0;
	endtask
	// stop: data rises while the clock is high, clock then stands high
	task automatic i2c_stop();
		#30 sda_low_out = 1'b1;
		#10 scl_out = 1'b1;
		#40 sda_low_out = 1'b0;
		#80;
	endtask
	// mode 0 byte: data set while clock low, sampled on the rise
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		#1 scl_out = 1'b0;
		ss_n_out = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#20 mosi_out = tx[i];
			#20 scl_out = 1'b1;
			rx[i] = sda_in;
			#40 scl_out = 1'b0;
		end
		#40 ss_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#80;
	endtask
endmodule // serial_host

// ### status_pin_and_port_mux.v
// lock, clock select and serial control pin mux with i2c/spi byte port
`include "status_pin_map.vh"

module status_pin_and_port_mux (
	input  wire       clk_sys_in,	// system clock, 200 MHz
	input  wire       nrst_in,	// synchronous reset, active low
	input  wire       ce_in,	// clock enable, freezes all state when low
	// configuration and internal state, same clock domain
	input  wire       pll_locked_in,	// 1 while the pll is locked
	input  wire       lock_out_enable_in,	// 1 drives the lock pin
	input  wire       lock_out_polarity_in,	// 0 active high, 1 inverted
	input  wire       auto_select_in,	// 1 automatic, 0 manual clock select
	input  wire       select_pin_enable_in,	// 1 takes clock select from pin
	input  wire       select_register_bit_in,	// register clock select
	input  wire       active_indicator_enable_in,	// 1 drives active clock on pin
	input  wire       active_clock_two_in,	// switch logic: clock two in use
	input  wire       alarm_one_in,	// alarm on input clock one
	input  wire       alarm_two_in,	// alarm on input clock two
	// pins
	output wire       lock_lost_out,	// lock pin level
	output wire       lock_lost_oe_out,	// lock pin output enable
	input  wire       clock_select_active_pin_in,	// select pin level in
	output wire       clock_select_active_pin_out,	// select pin level out
	output wire       clock_select_active_pin_oe_out,	// select pin enable
	input  wire       serial_clock_pin_in,	// serial clock from host
	input  wire       shared_serial_data_pin_in,	// data pin level in
	output wire       shared_serial_data_pin_out,	// data pin level out
	output wire       shared_serial_data_pin_oe_out,	// data pin enable
	input  wire       addr_pin_zero_in,	// address bit zero
	input  wire       addr_pin_one_in,	// address bit one
	input  wire       addr_two_or_select_pin_in,	// address two or spi select
	input  wire       control_mode_strap_in,	// 0 i2c, 1 spi
	input  wire       spi_serial_in_pin_in,	// spi data in
	// status
	output wire       lock_lost_status_out,	// 1 while unlocked
	output wire       active_input_status_out,	// 1 clock two active
	output wire       selected_clock_two_out,	// 1 clock two selected
	output wire       spi_mode_out,	// captured control mode
	// user byte port
	input  wire [7:0] tx_byte_in,	// byte to send on the next read
	output wire       tx_take_out,	// pulse: tx_byte_in loaded
	output wire [7:0] rx_byte_out,	// last received byte
	output wire       rx_valid_out,	// pulse: rx_byte_out is new
	output wire       addr_match_out	// pulse: i2c address matched
);

	// i2c states, one-hot
	localparam [4:0] ST_IDLE = 5'h01;	// waiting for start
	localparam [4:0] ST_ADDR = 5'h02;	// shifting address byte
	localparam [4:0] ST_AACK = 5'h04;	// acknowledging address
	localparam [4:0] ST_DATA = 5'h08;	// shifting data byte
	localparam [4:0] ST_DACK = 5'h10;	// acknowledge slot after data

	////////////////////////////////////////////////////////////////
	// pin synchronisers and edges

	wire [`LN_COUNT-1:0] raw_w;	// pins grouped for synchronising
	wire [`LN_COUNT-1:0] pin_w;	// synchronised pins
	wire [`ED_COUNT-1:0] rise_w;	// rising edges
	wire [`ED_COUNT-1:0] fall_w;	// falling edges

	assign raw_w[`LN_SCL]  = serial_clock_pin_in;
	assign raw_w[`LN_SDA]  = shared_serial_data_pin_in;
	assign raw_w[`LN_SS]   = addr_two_or_select_pin_in;
	assign raw_w[`LN_SDI]  = spi_serial_in_pin_in;
	assign raw_w[`LN_A0]   = addr_pin_zero_in;
	assign raw_w[`LN_A1]   = addr_pin_one_in;
	assign raw_w[`LN_MODE] = control_mode_strap_in;
	assign raw_w[`LN_CSEL] = clock_select_active_pin_in;

	line_sync #(.WIDTH(`LN_COUNT)) u_sync (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.async_in   (raw_w),
		.sync_out   (pin_w)
	);

	line_edges #(.WIDTH(`ED_COUNT)) u_edges (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.level_in   ({pin_w[`LN_SS], pin_w[`LN_SDA], pin_w[`LN_SCL]}),
		.rise_out   (rise_w),
		.fall_out   (fall_w)
	);

	// serial clock edges used in both modes
	wire scl_rise_w = rise_w[`ED_SCL];
	wire scl_fall_w = fall_w[`ED_SCL];
	wire scl_w      = pin_w[`LN_SCL];
	wire sda_w      = pin_w[`LN_SDA];

	////////////////////////////////////////////////////////////////
	// control mode strap, caught once after reset release

	reg       mode_q;	// captured strap
	reg       strap_taken_q;	// strap already caught
	reg [1:0] fill_q;	// enabled edges since release, up to the sync depth

	// the synchroniser shows its reset value for two enabled edges, so the
	// tied strap is caught once, only after real pin levels have come through
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			mode_q        <= `MODE_I2C;
			strap_taken_q <= 1'b0;
			fill_q        <= `SYNC_FIRST;
		end else if (ce_in) begin
			if (fill_q != `SYNC_FILLED) begin
				fill_q <= fill_q + `SYNC_STEP;
			end else if (strap_taken_q == 1'b0) begin
				strap_taken_q <= 1'b1;
				mode_q        <= pin_w[`LN_MODE];
			end
		end
	end

	wire spi_w = (mode_q == `MODE_SPI);
	wire i2c_w = strap_taken_q & ~spi_w;
	// slave select only acts in spi mode
	wire ss_act_w = spi_w & strap_taken_q & (pin_w[`LN_SS] == `SS_ACTIVE);

	////////////////////////////////////////////////////////////////
	// lock pin and lock status

	reg lock_out_q;	// lock pin level
	reg lock_oe_q;	// lock pin enable
	reg lock_stat_q;	// lock status bit

	// lock indication before and after polarity
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			lock_out_q  <= 1'b0;
			lock_oe_q   <= 1'b0;
			lock_stat_q <= `LOCK_LEVEL_LOST;
		end else if (ce_in) begin
			// status kept whatever the pin enable
			lock_stat_q <= pll_locked_in ? `LOCK_LEVEL_LOCKED : `LOCK_LEVEL_LOST;
			// driven only while enabled, else released
			lock_oe_q   <= lock_out_enable_in;
			// polarity bit inverts the driven level
			lock_out_q  <= (pll_locked_in ? `LOCK_LEVEL_LOCKED : `LOCK_LEVEL_LOST)
				^ (lock_out_polarity_in != `LOCK_POL_ACT_HIGH);
		end
	end

	////////////////////////////////////////////////////////////////
	// clock select and active clock indication

	reg active_q;	// active clock, held through double alarm
	reg sel_q;	// selected input clock
	reg cs_out_q;	// select pin level out
	reg cs_oe_q;	// select pin enable

	// the held indication avoids flapping while both inputs are bad
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			active_q <= `SEL_CLOCK_ONE;
			sel_q    <= `SEL_CLOCK_ONE;
			cs_out_q <= 1'b0;
			cs_oe_q  <= 1'b0;
		end else if (ce_in) begin
			// freeze on double alarm, else follow the switch
			if (!(alarm_one_in && alarm_two_in)) begin
				active_q <= active_clock_two_in;
			end
			if (auto_select_in) begin
				// automatic: selection is the active clock
				sel_q    <= active_q;
				// drive the indication only when enabled
				cs_oe_q  <= active_indicator_enable_in;
				cs_out_q <= active_q;
			end else begin
				// manual: pin is an input, never driven
				cs_oe_q  <= 1'b0;
				cs_out_q <= 1'b0;
				// the host holds the pin at a definite level
				if (select_pin_enable_in) begin
					sel_q <= pin_w[`LN_CSEL];
				end else begin
					sel_q <= select_register_bit_in;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// serial engine: i2c target and spi slave share one shifter

	reg [4:0] st_q;	// i2c state
	reg [7:0] sh_q;	// shift register
	reg [2:0] cnt_q;	// bit counter
	reg       done_q;	// eight bits shifted
	reg       rd_q;	// current i2c transfer is a read
	reg       sdo_q;	// data pin level out
	reg       sdo_oe_q;	// data pin enable
	reg [7:0] rx_q;	// received byte
	reg       rx_vld_q;	// received byte pulse
	reg       take_q;	// tx byte loaded pulse
	reg       match_q;	// address matched pulse

	// seven-bit target address: fixed upper bits then the address pins
	wire [6:0] my_addr_w = {`I2C_ADDR_HI, pin_w[`LN_SS], pin_w[`LN_A1], pin_w[`LN_A0]};
	// i2c start and stop conditions
	wire start_w = i2c_w & scl_w & fall_w[`ED_SDA];
	wire stop_w  = i2c_w & scl_w & rise_w[`ED_SDA];
	// shifted-in value for i2c
	wire [7:0] sh_i2c_w = {sh_q[6:0], sda_w};

	// counter advance with wrap flag
	function [3:0] bump;
		input [2:0] c;
		begin
			bump = {(c == `BIT_LAST), c + `BIT_STEP};
		end
	endfunction

	// one process for both modes; the strap keeps them apart
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			st_q     <= ST_IDLE;
			sh_q     <= 8'h00;
			cnt_q    <= `BIT_FIRST;
			done_q   <= 1'b0;
			rd_q     <= 1'b0;
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
			rx_q     <= 8'h00;
			rx_vld_q <= 1'b0;
			take_q   <= 1'b0;
			match_q  <= 1'b0;
		end else if (ce_in) begin
			rx_vld_q <= 1'b0;
			take_q   <= 1'b0;
			match_q  <= 1'b0;
			if (spi_w) begin
				// spi slave, mode 0; address zero and one unused
				st_q <= ST_IDLE;
				if (!ss_act_w) begin
					// deselected: output released
					sdo_oe_q <= 1'b0;
					cnt_q    <= `BIT_FIRST;
					done_q   <= 1'b1;
				end else if (scl_rise_w) begin
					// sample the dedicated data input
					sh_q  <= {sh_q[6:0], pin_w[`LN_SDI]};
					{done_q, cnt_q} <= bump(cnt_q);
					if (cnt_q == `BIT_LAST) begin
						rx_q     <= {sh_q[6:0], pin_w[`LN_SDI]};
						rx_vld_q <= 1'b1;
					end
				end else if (scl_fall_w || fall_w[`ED_SS]) begin
					// shared pin is a push-pull output in spi
					sdo_oe_q <= 1'b1;
					if (done_q) begin
						sh_q   <= tx_byte_in;
						sdo_q  <= tx_byte_in[7];
						take_q <= 1'b1;
						done_q <= 1'b0;
					end else begin
						sdo_q <= sh_q[7];
					end
				end
			end else if (start_w) begin
				// start or repeated start
				st_q     <= ST_ADDR;
				cnt_q    <= `BIT_FIRST;
				done_q   <= 1'b0;
				sdo_oe_q <= 1'b0;
			end else if (stop_w) begin
				st_q     <= ST_IDLE;
				sdo_oe_q <= 1'b0;
			end else if (i2c_w) begin
				// open-drain data line: only ever pulls low
				sdo_q <= 1'b0;
				case (st_q)
					ST_ADDR: begin
						if (scl_rise_w) begin
							sh_q <= sh_i2c_w;
							{done_q, cnt_q} <= bump(cnt_q);
						end else if (scl_fall_w && done_q) begin
							done_q <= 1'b0;
							if (sh_q[7:1] == my_addr_w) begin
								st_q     <= ST_AACK;
								rd_q     <= (sh_q[0] == `I2C_RW_READ);
								sdo_oe_q <= (`I2C_ACK_LEVEL == 1'b0);
								match_q  <= 1'b1;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall_w) begin
							st_q  <= ST_DATA;
							cnt_q <= `BIT_FIRST;
							if (rd_q) begin
								// first read bit goes out now
								sh_q     <= tx_byte_in;
								take_q   <= 1'b1;
								sdo_oe_q <= ~tx_byte_in[7];
							end else begin
								sdo_oe_q <= 1'b0;
							end
						end
					end
					ST_DATA: begin
						if (scl_rise_w) begin
							if (!rd_q) begin
								sh_q <= sh_i2c_w;
							end
							{done_q, cnt_q} <= bump(cnt_q);
						end else if (scl_fall_w) begin
							if (done_q) begin
								done_q <= 1'b0;
								st_q   <= ST_DACK;
								if (rd_q) begin
									// master acknowledges the byte
									sdo_oe_q <= 1'b0;
								end else begin
									rx_q     <= sh_q;
									rx_vld_q <= 1'b1;
									sdo_oe_q <= (`I2C_ACK_LEVEL == 1'b0);
								end
							end else if (rd_q) begin
								sh_q     <= {sh_q[6:0], 1'b0};
								sdo_oe_q <= ~sh_q[6];
							end
						end
					end
					ST_DACK: begin
						if (scl_rise_w && rd_q && (sda_w == `I2C_NACK_LEVEL)) begin
							// not-acknowledged read ends the transfer
							st_q <= ST_IDLE;
						end else if (scl_fall_w) begin
							st_q  <= ST_DATA;
							cnt_q <= `BIT_FIRST;
							if (rd_q) begin
								sh_q     <= tx_byte_in;
								take_q   <= 1'b1;
								sdo_oe_q <= ~tx_byte_in[7];
							end else begin
								sdo_oe_q <= 1'b0;
							end
						end
					end
					ST_IDLE: begin
						sdo_oe_q <= 1'b0;
					end
					default: begin
						st_q     <= ST_IDLE;
						sdo_oe_q <= 1'b0;
					end
				endcase
			end else begin
				// strap not yet caught: keep the pin released
				sdo_oe_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign lock_lost_out                  = lock_out_q;
	assign lock_lost_oe_out               = lock_oe_q;
	assign lock_lost_status_out           = lock_stat_q;
	assign clock_select_active_pin_out    = cs_out_q;
	assign clock_select_active_pin_oe_out = cs_oe_q;
	assign active_input_status_out        = active_q;
	assign selected_clock_two_out         = sel_q;
	assign spi_mode_out                   = mode_q;
	assign shared_serial_data_pin_out     = sdo_q;
	assign shared_serial_data_pin_oe_out  = sdo_oe_q;
	assign rx_byte_out                    = rx_q;
	assign rx_valid_out                   = rx_vld_q;
	assign tx_take_out                    = take_q;
	assign addr_match_out                 = match_q;

endmodule // status_pin_and_port_mux

// ### status_pin_and_port_mux_checker.sv
// concurrent checks on the status pin and serial port mux ports
module status_pin_and_port_mux_checker (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic pll_locked_in,
	input wire logic lock_out_enable_in,
	input wire logic lock_out_polarity_in,
	input wire logic auto_select_in,
	input wire logic select_pin_enable_in,
	input wire logic select_register_bit_in,
	input wire logic active_indicator_enable_in,
	input wire logic active_clock_two_in,
	input wire logic alarm_one_in,
	input wire logic alarm_two_in,
	input wire logic clock_select_active_pin_in,
	input wire logic addr_two_or_select_pin_in,
	input wire logic lock_lost_out,
	input wire logic lock_lost_oe_out,
	input wire logic clock_select_active_pin_out,
	input wire logic clock_select_active_pin_oe_out,
	input wire logic shared_serial_data_pin_out,
	input wire logic shared_serial_data_pin_oe_out,
	input wire logic lock_lost_status_out,
	input wire logic active_input_status_out,
	input wire logic selected_clock_two_out,
	input wire logic spi_mode_out
);
	// every check runs on the system clock and sleeps in reset
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	lock_level_a: assert property (
		ce_in |=> lock_lost_out == ($past(lock_out_polarity_in) ^ !$past(pll_locked_in)))
		else $error("lock pin level wrong");
	lock_enable_a: assert property (
		ce_in |=> lock_lost_oe_out == $past(lock_out_enable_in))
		else $error("lock pin enable wrong");
	lock_status_a: assert property (
		ce_in |=> lock_lost_status_out == !$past(pll_locked_in))
		else $error("lock status wrong");
	ind_enable_a: assert property (
		ce_in |=> clock_select_active_pin_oe_out ==
			$past(auto_select_in && active_indicator_enable_in))
		else $error("indicator enable wrong");
	active_hold_a: assert property (
		ce_in && alarm_one_in && alarm_two_in |=> $stable(active_input_status_out))
		else $error("active clock moved in hold");
	active_follow_a: assert property (
		ce_in && auto_select_in && !(alarm_one_in && alarm_two_in)
		|=> active_input_status_out == $past(active_clock_two_in))
		else $error("active status stale");
	ind_pin_a: assert property (
		ce_in && auto_select_in |=> clock_select_active_pin_out == $past(active_input_status_out))
		else $error("indicator pin level wrong");
	reg_select_a: assert property (
		(ce_in && !auto_select_in && !select_pin_enable_in && $stable(select_register_bit_in))[*3]
		|-> selected_clock_two_out == select_register_bit_in)
		else $error("register select ignored");
	pin_select_a: assert property (
		(ce_in && !auto_select_in && select_pin_enable_in && $stable(clock_select_active_pin_in))[*5]
		|-> selected_clock_two_out == clock_select_active_pin_in)
		else $error("pin select ignored");
	sda_open_a: assert property (
		shared_serial_data_pin_oe_out && !spi_mode_out |-> !shared_serial_data_pin_out)
		else $error("i2c data driven high");
	spi_idle_a: assert property (
		(ce_in && spi_mode_out && addr_two_or_select_pin_in)[*4] |-> !shared_serial_data_pin_oe_out)
		else $error("spi output driven while deselected");
endmodule // status_pin_and_port_mux_checker

bind status_pin_and_port_mux status_pin_and_port_mux_checker checker_i (.*);

// ### status_pin_map.vh
// named constants for the status pin and serial port pin mux
`ifndef STATUS_PIN_MAP_VH
`define STATUS_PIN_MAP_VH

// control mode strap levels
`define MODE_I2C           1'b0
`define MODE_SPI           1'b1

// lock output polarity: this value keeps the pin active high (1 = unlocked)
`define LOCK_POL_ACT_HIGH  1'b0
// internal lock indication levels before polarity
`define LOCK_LEVEL_LOCKED  1'b0
`define LOCK_LEVEL_LOST    1'b1

// clock select encodings
`define SEL_CLOCK_ONE      1'b0
`define SEL_CLOCK_TWO      1'b1

// fixed upper bits of the serial target address
`define I2C_ADDR_HI        4'hd
// i2c read/write bit level for a read
`define I2C_RW_READ        1'b1
// level the device pulls sda to when acknowledging
`define I2C_ACK_LEVEL      1'b0
// level of a master not-acknowledge
`define I2C_NACK_LEVEL     1'b1

// spi slave select is active at this level
`define SS_ACTIVE          1'b0

// synchroniser lane positions
`define LN_SCL             0
`define LN_SDA             1
`define LN_SS              2
`define LN_SDI             3
`define LN_A0              4
`define LN_A1              5
`define LN_MODE            6
`define LN_CSEL            7
`define LN_COUNT           8

// edge detector lane positions
`define ED_SCL             0
`define ED_SDA             1
`define ED_SS              2
`define ED_COUNT           3

// enabled edges the pin synchroniser needs before its output is real
`define SYNC_FIRST         2'h0
`define SYNC_FILLED        2'h2
`define SYNC_STEP          2'h1

// bit counter values
`define BIT_FIRST          3'h0
`define BIT_LAST           3'h7
`define BIT_STEP           3'h1

`endif

// ### tb_top.sv
// self-checking bench for the status pin and serial port mux
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys_in, nrst_in;	// clock and reset
	logic       locked, lk_en, lk_pol;	// lock state and pin setup
	logic       auto_sel, pin_en, sel_reg, ind_en;	// clock select setup
	logic       act_two, al_one, al_two, csel_drv;	// switch state, board level
	logic       a0, a1, strap, ack, am_seen, ce_en;	// straps, enable, event flags
	logic [7:0] tx_byte, rx_got, spi_rx, i2c_rx;	// byte port values
	int         fails, samples_checked, cyc, takes;	// counters
	wire        lk_out, lk_oe, cs_out, cs_oe, sdo, sdo_oe, lk_st, act_st, sel_two;
	wire        spi_md, take, rx_vld, am, scl, sda_low, ss_n, mosi, csel_w, sda_w;
	wire [7:0]  rx_byte;	// received byte
	// board level on the select pin unless the device drives it
	assign csel_w = cs_oe ? cs_out : csel_drv;
	// i2c line has a pull-up; a released spi output shows the inverse
	assign sda_w = strap ? (sdo_oe ? sdo : ~sdo) : ~(sda_low | (sdo_oe & ~sdo));
	status_pin_and_port_mux dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce_en),
		.pll_locked_in(locked), .lock_out_enable_in(lk_en), .lock_out_polarity_in(lk_pol),
		.auto_select_in(auto_sel), .select_pin_enable_in(pin_en),
		.select_register_bit_in(sel_reg), .active_indicator_enable_in(ind_en),
		.active_clock_two_in(act_two), .alarm_one_in(al_one), .alarm_two_in(al_two),
		.lock_lost_out(lk_out), .lock_lost_oe_out(lk_oe), .clock_select_active_pin_in(csel_w),
		.clock_select_active_pin_out(cs_out), .clock_select_active_pin_oe_out(cs_oe),
		.serial_clock_pin_in(scl), .shared_serial_data_pin_in(sda_w),
		.shared_serial_data_pin_out(sdo), .shared_serial_data_pin_oe_out(sdo_oe),
		.addr_pin_zero_in(a0), .addr_pin_one_in(a1), .addr_two_or_select_pin_in(ss_n),
		.control_mode_strap_in(strap), .spi_serial_in_pin_in(mosi),
		.lock_lost_status_out(lk_st), .active_input_status_out(act_st),
		.selected_clock_two_out(sel_two), .spi_mode_out(spi_md), .tx_byte_in(tx_byte),
		.tx_take_out(take), .rx_byte_out(rx_byte), .rx_valid_out(rx_vld),
		.addr_match_out(am));
	serial_host host (.scl_out(scl), .sda_low_out(sda_low), .ss_n_out(ss_n),
		.mosi_out(mosi), .sda_in(sda_w));
	// 200 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// catch the one-cycle byte and address pulses
	always @(posedge clk_sys_in) begin
		if (rx_vld) begin
			rx_got <= rx_byte;
		end
		if (am) begin
			am_seen <= 1'b1;
		end
		if (take) begin
			takes <= takes + 1;
		end
	end
	// hang guard
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			end_of_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	// reset for ten cycles with the mode strap already settled
	task automatic do_reset(input logic s);
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		strap <= s;
		tick(10);
		nrst_in <= 1'b1;
		tick(6);
	endtask
	task automatic end_of_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		nrst_in = 1'b0;
		{locked, lk_en, lk_pol, auto_sel, pin_en, sel_reg, ind_en, act_two} = '0;
		{al_one, al_two, csel_drv, a0, a1, strap, ack, am_seen, tx_byte, rx_got} = '0;
		ce_en = 1'b1;
		do_reset(1'b0);
		// lock pin over every enable, polarity and lock combination
		for (int i = 0; i < 8; i++) begin
			{lk_en, lk_pol, locked} <= i[2:0];
			tick(2);
			chk1(lk_oe, i[2]);
			chk1(lk_out, ~i[0] ^ i[1]);
			chk1(lk_st, ~i[0]);
		end
		// a low clock enable freezes the status, raising it lets it move
		ce_en <= 1'b0;
		locked <= 1'b0;
		tick(3);
		chk1(lk_st, 1'b0);
		ce_en <= 1'b1;
		tick(2);
		chk1(lk_st, 1'b1);
		// manual selection from the register bit, then from the pin
		for (int i = 0; i < 4; i++) begin
			{pin_en, csel_drv, sel_reg} <= {i[1], i[0], ~i[0]};
			tick(7);
			chk1(sel_two, i[1] ? i[0] : ~i[0]);
			chk1(cs_oe, 1'b0);
		end
		// automatic selection drives the indicator, holds with both alarms
		{auto_sel, ind_en, act_two} <= 3'b111;
		tick(4);
		chk1(act_st, 1'b1);
		chk1(cs_out, 1'b1);
		chk1(cs_oe, 1'b1);
		{al_one, al_two, act_two} <= 3'b110;
		tick(4);
		chk1(cs_out, 1'b1);
		chk1(act_st, 1'b1);
		{al_one, al_two, ind_en} <= 3'b000;
		tick(4);
		chk1(cs_oe, 1'b0);
		chk1(act_st, 1'b0);
		// i2c write to 1101 then a2=1 a1=0 a0=1, then a wrong address
		{a0, a1} <= 2'b10;
		tx_byte <= 8'h3c;
		tick(6);
		host.i2c_start();
		host.i2c_byte(8'hda, ack, i2c_rx);
		chk1(ack, 1'b1);
		chk1(am_seen, 1'b1);
		host.i2c_byte(8'ha5, ack, i2c_rx);
		chk1(ack, 1'b1);
		host.i2c_stop();
		chk8(rx_got, 8'ha5);
		host.i2c_start();
		host.i2c_byte(8'hd8, ack, i2c_rx);
		chk1(ack, 1'b0);
		host.i2c_stop();
		// i2c read of one byte, ended by a master not-acknowledge
		host.i2c_start();
		host.i2c_byte(8'hdb, ack, i2c_rx);
		chk1(ack, 1'b1);
		host.i2c_byte(8'hff, ack, i2c_rx);
		chk8(i2c_rx, 8'h3c);
		chk1(ack, 1'b0);
		host.i2c_stop();
		// spi exchange with the address pins at other levels
		do_reset(1'b1);
		{a0, a1} <= 2'b01;
		tx_byte <= 8'h5a;
		tick(2);
		chk1(sdo_oe, 1'b0);
		chk1(spi_md, 1'b1);
		host.spi_byte(8'h96, spi_rx);
		chk8(spi_rx, 8'h5a);
		chk8(rx_got, 8'h96);
		chk8(takes[7:0], 8'h03);
		end_of_test();
	end
endmodule // tb_top
